// *** verilog/stamp_regs_pkg.sv ***
package stamp_regs_pkg;

   // ****************************************
   // Widths and field layout
   // ****************************************
   localparam int CODE_W    = 10;
   localparam int STAMP_W   = 6;
   localparam int REG_W     = 16;
   localparam int NUM_REGS  = 6;
   localparam int ADDR_W    = 3;
   localparam int CODE_LSB  = 0;
   localparam int CODE_MSB  = 9;
   localparam int STAMP_LSB = 10;
   localparam int STAMP_MSB = 15;

   typedef logic [ADDR_W-1:0]  reg_idx_t;
   typedef logic [ADDR_W-1:0]  chan_t;
   typedef logic [CODE_W-1:0]  code_t;
   typedef logic [STAMP_W-1:0] stamp_t;
   typedef logic [REG_W-1:0]   result_t;

   // ****************************************
   // Reset values and counter limits
   // ****************************************
   localparam result_t RESULT_RESET = 16'h0000;
   localparam stamp_t  STAMP_RESET  = 6'h00;
   localparam stamp_t  STAMP_MAX    = 6'h3f;
   localparam stamp_t  STAMP_STEP   = 6'h01;

   // ****************************************
   // Register indices on the read port
   // ****************************************
   localparam reg_idx_t REG_IDX_INPUT_ONE   = 3'h0;
   localparam reg_idx_t REG_IDX_INPUT_THREE = 3'h1;
   localparam reg_idx_t REG_IDX_INPUT_FIVE  = 3'h2;
   localparam reg_idx_t REG_IDX_INPUT_TWO   = 3'h3;
   localparam reg_idx_t REG_IDX_INPUT_FOUR  = 3'h4;
   localparam reg_idx_t REG_IDX_INPUT_SIX   = 3'h5;
   localparam reg_idx_t REG_IDX_NONE        = 3'h7;

   // ****************************************
   // Converter channel numbers
   // ****************************************
   localparam chan_t CHAN_ONE   = 3'h0;
   localparam chan_t CHAN_TWO   = 3'h1;
   localparam chan_t CHAN_THREE = 3'h2;
   localparam chan_t CHAN_FOUR  = 3'h3;
   localparam chan_t CHAN_FIVE  = 3'h4;
   localparam chan_t CHAN_SIX   = 3'h5;

endpackage

// *** verilog/stamp_if.sv ***
`timescale 1ns/1ps
interface stamp_if;
   import stamp_regs_pkg::*;
   stamp_t stamp;
   logic   step;
   modport source (output stamp, output step);
   modport sink   (input stamp, input step);
endinterface

// *** verilog/stamp_counter.sv ***
`timescale 1ns/1ps
module stamp_counter
   import stamp_regs_pkg::*;
(
   input  wire logic clk,               // System clock
   input  wire logic sys_rst,           // Synchronous reset, high
   input  wire logic pwm_control_input, // PWM control level
   stamp_if.source   st                 // Counter value and step
);

   // ****************************************
   // Edge detect and counter
   // ****************************************
   logic   prev_q;
   logic   prev_d;
   logic   armed_q;
   logic   armed_d;
   stamp_t count_q;
   stamp_t count_d;
   logic   edge_seen;

   always_comb
   begin
      edge_seen = armed_q && (pwm_control_input != prev_q);
      prev_d    = pwm_control_input;
      armed_d   = 1'b1;
      count_d   = count_q;
      if (edge_seen)
      begin
         count_d = stamp_t'(count_q + STAMP_STEP);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prev_q  <= 1'b0;
         armed_q <= 1'b0;
         count_q <= STAMP_RESET;
      end
      else
      begin
         prev_q  <= prev_d;
         armed_q <= armed_d;
         count_q <= count_d;
      end
   end

   assign st.stamp = count_q;
   assign st.step  = edge_seen;

   // ****************************************
   // Checks
   // ****************************************
   a_edge_steps: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) && pwm_control_input != $past(pwm_control_input) |-> edge_seen)
      else $error("PWM edge did not step counter");
   a_count_advance: assert property (@(posedge clk) disable iff (sys_rst)
      edge_seen |=> count_q == stamp_t'($past(count_q) + STAMP_STEP))
      else $error("Counter did not advance by one");
   a_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !edge_seen |=> count_q == $past(count_q))
      else $error("Counter moved without an edge");
   a_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      edge_seen && count_q == STAMP_MAX |=> count_q == STAMP_RESET)
      else $error("Counter did not wrap to zero");
   a_count_reset: assert property (@(posedge clk)
      sys_rst |=> count_q == STAMP_RESET)
      else $error("Counter not cleared by reset");

endmodule

// *** verilog/adc_result_timestamp_regs.sv ***
`timescale 1ns/1ps
module adc_result_timestamp_regs
(
   input  wire logic                     clk,               // System clock
   input  wire logic                     sys_rst,           // Synchronous reset, high
   input  wire logic                     pwm_control_input, // PWM control level
   input  wire logic                     conv_done,         // Valid conversion pulse
   input  wire stamp_regs_pkg::chan_t    conv_chan,         // Channel of conversion
   input  wire stamp_regs_pkg::code_t    conv_code,         // Conversion code
   input  wire logic                     reg_rd_en,         // Register read strobe
   input  wire logic                     reg_wr_en,         // Register write strobe
   input  wire stamp_regs_pkg::reg_idx_t reg_addr,          // Register index
   output logic                          rd_valid,          // Read data valid
   output stamp_regs_pkg::result_t       rd_data,           // Read data
   output logic                          wr_ignored,        // Write was discarded
   output stamp_regs_pkg::stamp_t        stamp_now          // Live counter value
);
   import stamp_regs_pkg::*;

   // ****************************************
   // Channel to register map
   // ****************************************
   function automatic reg_idx_t chan_to_reg(input chan_t chan);
      reg_idx_t idx;
      idx = REG_IDX_NONE;
      case (chan)
         CHAN_ONE:   idx = REG_IDX_INPUT_ONE;
         CHAN_THREE: idx = REG_IDX_INPUT_THREE;
         CHAN_FIVE:  idx = REG_IDX_INPUT_FIVE;
         CHAN_TWO:   idx = REG_IDX_INPUT_TWO;
         CHAN_FOUR:  idx = REG_IDX_INPUT_FOUR;
         CHAN_SIX:   idx = REG_IDX_INPUT_SIX;
         default:    idx = REG_IDX_NONE;
      endcase
      return idx;
   endfunction

   // ****************************************
   // Time stamp counter
   // ****************************************
   stamp_if st ();

   stamp_counter u_counter
   (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .pwm_control_input (pwm_control_input),
      .st                (st.source)
   );

   assign stamp_now = st.stamp;

   // ****************************************
   // Result registers
   // ****************************************
   result_t  result_q [NUM_REGS];
   result_t  result_d [NUM_REGS];
   reg_idx_t target;

   assign target = conv_done ? chan_to_reg(conv_chan) : REG_IDX_NONE;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++)
      begin : g_result
         always_comb
         begin
            result_d[gi] = result_q[gi];
            if (target == reg_idx_t'(gi))
            begin
               result_d[gi] = {st.stamp, conv_code};
            end
         end

         always_ff @(posedge clk)
         begin
            if (sys_rst)
            begin
               result_q[gi] <= RESULT_RESET;
            end
            else
            begin
               result_q[gi] <= result_d[gi];
            end
         end

         a_load_on_hit: assert property (@(posedge clk) disable iff (sys_rst)
            target == reg_idx_t'(gi) |=>
               result_q[gi][STAMP_MSB:STAMP_LSB] == $past(st.stamp)
               && result_q[gi][CODE_MSB:CODE_LSB] == $past(conv_code))
            else $error("Result register missed a conversion");
         a_hold_no_hit: assert property (@(posedge clk) disable iff (sys_rst)
            target != reg_idx_t'(gi) |=> $stable(result_q[gi]))
            else $error("Result register changed without a conversion");
         a_reset_zero: assert property (@(posedge clk)
            sys_rst |=> result_q[gi] == RESULT_RESET)
            else $error("Result register not zero after reset");
      end
   endgenerate

   // ****************************************
   // Read port
   // ****************************************
   logic    rd_valid_q;
   logic    rd_valid_d;
   result_t rd_data_q;
   result_t rd_data_d;
   logic    wr_ign_q;
   logic    wr_ign_d;

   always_comb
   begin
      rd_valid_d = reg_rd_en;
      rd_data_d  = rd_data_q;
      wr_ign_d   = reg_wr_en;
      if (reg_rd_en)
      begin
         if (reg_addr < reg_idx_t'(NUM_REGS))
         begin
            rd_data_d = result_q[reg_addr];
         end
         else
         begin
            rd_data_d = RESULT_RESET;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= RESULT_RESET;
         wr_ign_q   <= 1'b0;
      end
      else
      begin
         rd_valid_q <= rd_valid_d;
         rd_data_q  <= rd_data_d;
         wr_ign_q   <= wr_ign_d;
      end
   end

   assign rd_valid   = rd_valid_q;
   assign rd_data    = rd_data_q;
   assign wr_ignored = wr_ign_q;

   // ****************************************
   // Checks on map and access
   // ****************************************
   a_map_one: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_ONE |=>
         result_q[REG_IDX_INPUT_ONE][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input one not in first register");
   a_map_three: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_THREE |=>
         result_q[REG_IDX_INPUT_THREE][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input three not in second register");
   a_map_five: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_FIVE |=>
         result_q[REG_IDX_INPUT_FIVE][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input five not in third register");
   a_map_two: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_TWO |=>
         result_q[REG_IDX_INPUT_TWO][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input two not in fourth register");
   a_map_four: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_FOUR |=>
         result_q[REG_IDX_INPUT_FOUR][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input four not in fifth register");
   a_map_six: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan == CHAN_SIX |=>
         result_q[REG_IDX_INPUT_SIX][CODE_MSB:CODE_LSB] == $past(conv_code))
      else $error("Input six not in sixth register");
   a_write_ignored: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr_en && !conv_done |=> wr_ignored
         && $stable(result_q[REG_IDX_INPUT_ONE]) && $stable(result_q[REG_IDX_INPUT_SIX]))
      else $error("Write disturbed a result register");
   a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd_en && reg_addr == REG_IDX_INPUT_TWO |=>
         rd_valid && rd_data == $past(result_q[REG_IDX_INPUT_TWO]))
      else $error("Read returned wrong register");

   // ****************************************
   // Checks on counter link, unused channels and read and write timing
   // ****************************************
   a_step_moves: assert property (@(posedge clk) disable iff (sys_rst)
      st.step |=>
         st.stamp == stamp_t'($past(st.stamp) + STAMP_STEP))
      else $error("Counter step not seen on stamp");
   a_bad_chan_kept: assert property (@(posedge clk) disable iff (sys_rst)
      conv_done && conv_chan > CHAN_SIX |=>
         $stable(result_q[REG_IDX_INPUT_ONE]) && $stable(result_q[REG_IDX_INPUT_TWO])
         && $stable(result_q[REG_IDX_INPUT_THREE]) && $stable(result_q[REG_IDX_INPUT_FOUR])
         && $stable(result_q[REG_IDX_INPUT_FIVE]) && $stable(result_q[REG_IDX_INPUT_SIX]))
      else $error("Unused channel changed a result register");
   a_read_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd_en && reg_addr < reg_idx_t'(NUM_REGS) |=>
         rd_valid && rd_data == $past(result_q[reg_addr]))
      else $error("Read not answered from its register");
   a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd_en |=> !rd_valid && $stable(rd_data))
      else $error("Read port moved without a request");
   a_read_unused: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd_en && reg_addr > REG_IDX_INPUT_SIX |=> rd_data == RESULT_RESET)
      else $error("Unused index read nonzero");
   a_write_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_wr_en |=> !wr_ignored)
      else $error("Write flag without a write");

endmodule

// *** sim/adc_result_timestamp_regs_test.sv ***
`timescale 1ns/1ps
module adc_result_timestamp_regs_test;
   import stamp_regs_pkg::*;

   // ****************************************
   // Signals and expectations
   // ****************************************
   logic     clk;
   logic     sys_rst;
   logic     pwm_control_input;
   logic     conv_done;
   chan_t    conv_chan;
   code_t    conv_code;
   logic     reg_rd_en;
   logic     reg_wr_en;
   reg_idx_t reg_addr;
   logic     rd_valid;
   result_t  rd_data;
   logic     wr_ignored;
   stamp_t   stamp_now;
   int       errors;
   int       comparisons;
   stamp_t   exp_st;
   result_t  exp_reg [8];
   chan_t    chans [6] = '{CHAN_ONE, CHAN_TWO, CHAN_THREE, CHAN_FOUR, CHAN_FIVE, CHAN_SIX};
   reg_idx_t idx_of [6] = '{REG_IDX_INPUT_ONE, REG_IDX_INPUT_TWO, REG_IDX_INPUT_THREE,
                            REG_IDX_INPUT_FOUR, REG_IDX_INPUT_FIVE, REG_IDX_INPUT_SIX};
   code_t    codes [6] = '{10'h3ff, 10'h001, 10'h2aa, 10'h155, 10'h200, 10'h0f0};

   adc_result_timestamp_regs i_dut (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .pwm_control_input (pwm_control_input),
      .conv_done         (conv_done),
      .conv_chan         (conv_chan),
      .conv_code         (conv_code),
      .reg_rd_en         (reg_rd_en),
      .reg_wr_en         (reg_wr_en),
      .reg_addr          (reg_addr),
      .rd_valid          (rd_valid),
      .rd_data           (rd_data),
      .wr_ignored        (wr_ignored),
      .stamp_now         (stamp_now)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic finish_test;
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk_word(input result_t got, input result_t exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_stamp(input stamp_t got, input stamp_t exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: stamp %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: strobe %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic do_reset;
      sys_rst = 1'b1;
      repeat (2) tick;
      sys_rst = 1'b0;
      repeat (2) tick;
      exp_st = STAMP_RESET;
      foreach (exp_reg[i]) exp_reg[i] = RESULT_RESET;
   endtask

   // Back-to-back reads of every index, unused ones included
   task automatic rd_all;
      for (int i = 0; i < 8; i++)
      begin
         reg_rd_en = 1'b1;
         reg_addr = reg_idx_t'(i);
         tick;
         chk_bit(rd_valid, 1'b1);
         chk_word(rd_data, exp_reg[i]);
      end
      reg_rd_en = 1'b0;
      tick;
      chk_bit(rd_valid, 1'b0);
   endtask

   task automatic conv(input chan_t ch, input code_t cd);
      conv_done = 1'b1;
      conv_chan = ch;
      conv_code = cd;
      tick;
      conv_done = 1'b0;
      tick;
   endtask

   task automatic toggle;
      pwm_control_input = ~pwm_control_input;
      tick;
      exp_st = exp_st + STAMP_STEP;
   endtask

   task automatic wr(input reg_idx_t a);
      reg_wr_en = 1'b1;
      reg_addr = a;
      tick;
      reg_wr_en = 1'b0;
      chk_bit(wr_ignored, 1'b1);
      tick;
      chk_bit(wr_ignored, 1'b0);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      errors = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      pwm_control_input = 1'b0;
      conv_done = 1'b0;
      conv_chan = CHAN_ONE;
      conv_code = 10'h000;
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr = 3'h0;
      do_reset;
      rd_all;
      chk_stamp(stamp_now, STAMP_RESET);
      for (int c = 0; c < 6; c++)
      begin
         exp_reg[idx_of[c]] = {exp_st, codes[c]};
         conv(chans[c], codes[c]);
         toggle;
      end
      rd_all;
      for (int i = 0; i < 8; i++) wr(reg_idx_t'(i));
      conv(3'h6, 10'h0aa);
      conv(3'h7, 10'h055);
      rd_all;
      repeat (64)
      begin
         toggle;
         chk_stamp(stamp_now, exp_st);
      end
      exp_reg[REG_IDX_INPUT_FIVE] = {exp_st, 10'h123};
      conv(CHAN_FIVE, 10'h123);
      repeat (3) toggle;
      rd_all;
      do_reset;
      rd_all;
      chk_stamp(stamp_now, STAMP_RESET);
      finish_test;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      finish_test;
   end

endmodule
